// >>> mcud_decoder.sv
// instruction word decoder, cycle sequencer and register slave
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module mcud_decoder
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic fetch_valid,
   input wire logic [mcud_pkg::WORD_W-1:0] fetch_word,
   output logic fetch_ready,
   input wire logic branch_taken,
   input wire logic [mcud_pkg::BANK_W-1:0] bank_select_reg,
   input wire logic alu_upd,
   input wire logic alu_sub,
   input wire logic [mcud_pkg::DATA_W-1:0] alu_a,
   input wire logic [mcud_pkg::DATA_W-1:0] alu_b,
   output logic exec_start,
   output mcud_pkg::mcud_dec_s exec_dec,
   output logic exec_we,
   output logic [mcud_pkg::FADDR_W-1:0] data_addr,
   output logic wr_accum,
   output logic wr_file,
   output logic shadow_save,
   output logic shadow_restore,
   output logic tbl_pre_inc,
   output logic tbl_post_inc,
   output logic tbl_post_dec,
   output logic [mcud_pkg::PH_W-1:0] cyc_phase,
   output mcud_pkg::mcud_flags_s status_flags,
   input wire logic [mcud_pkg::AXI_ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [mcud_pkg::AXI_DATA_W-1:0] wdata,
   input wire logic [mcud_pkg::AXI_STRB_W-1:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [mcud_pkg::AXI_ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [mcud_pkg::AXI_DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);
   import mcud_pkg::*;
   typedef struct packed {
      mcud_seq_e seq;
      logic busy;
      logic start;
      logic ill;
      logic [WORD_W-1:0] w1;
      logic [WORD_W-1:0] last_w;
      mcud_dec_s dec;
      logic [AXI_DATA_W-1:0] ctrl;
      logic [AXI_DATA_W-1:0] cycles;
      logic aw_done;
      logic w_done;
      logic [AXI_ADDR_W-1:0] awaddr;
      logic [AXI_DATA_W-1:0] wdata;
      logic [AXI_STRB_W-1:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [AXI_DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } mcud_st_s;
   mcud_st_s st_reg;
   mcud_st_s st_next;
   logic cyc_last;
   logic redir;
   logic take;
   logic iss;
   mcud_dec_s first;
   mcud_dec_s idec;
   logic [WORD_W-1:0] iw;
   mcud_flags_s flags_q;
   // ---------------------------------------
   // word decode
   // ---------------------------------------
   function automatic mcud_dec_s dec_word(
      input logic [WORD_W-1:0] a,
      input logic [WORD_W-1:0] b,
      input logic ext_en
   );
      mcud_dec_s d;
      logic [3:0] top;
      logic [2:0] sub;
      d = '0;
      top = a[P_TOP_H:P_TOP_L];
      sub = a[P_SUB_H:P_SUB_L];
      d.to_file = a[P_D];
      d.banked = a[P_A];
      d.bitn = a[P_B_H:P_B_L];
      d.fa = a[P_F_H:0];
      d.lit = LIT_W'(a[P_F_H:0]);
      if (top <= TOP_BYTE_MAX)
      begin
         d.cls = CL_BYTE;
         d.cond = (top == TOP_BYTE_SKIP);
      end
      else if (top <= TOP_BIT_MAX)
      begin
         d.cls = CL_BIT;
         d.cond = (top == TOP_BIT_SKIP);
      end
      else if (top == TOP_LIT)
         d.cls = CL_LIT;
      else if (top == TOP_PTR)
      begin
         d.cls = CL_PTR;
         d.two_word = 1'b1;
         d.psel = a[P_PS_H:P_PS_L];
         d.lit = LIT_W'({a[P_KN_H:0], b[P_F_H:0]});
      end
      else if (top == TOP_MOVE)
      begin
         d.cls = CL_MOVE;
         d.two_word = 1'b1;
         d.fs = a[P_FS_H:0];
         d.fd = b[P_FS_H:0];
      end
      else if (top == TOP_BRA)
      begin
         d.cls = CL_BRA;
         if (a[P_BRC])
         begin
            d.cond = 1'b1;
            d.lit = LIT_W'($signed(a[P_F_H:0]));
         end
         else
         begin
            d.redirect = 1'b1;
            d.lit = LIT_W'($signed(a[P_REL_H:0]));
         end
      end
      else if (top == TOP_CTL)
      begin
         case (sub)
            SUB_GOTO, SUB_CALL:
            begin
               d.cls = (sub == SUB_GOTO) ? CL_GOTO : CL_CALL;
               d.two_word = 1'b1;
               d.redirect = 1'b1;
               d.fast = (sub == SUB_CALL) && a[P_S];
               d.lit = {b[P_FS_H:0], a[P_F_H:0]};
            end
            SUB_RET:
            begin
               d.cls = CL_RET;
               d.redirect = 1'b1;
               d.fast = a[P_S];
            end
            SUB_TBLRD, SUB_TBLWT:
            begin
               d.cls = (sub == SUB_TBLRD) ? CL_TBLRD : CL_TBLWT;
               d.tmode = mcud_tmode_e'(a[P_TM_H:0]);
            end
            SUB_NOP:
               d.cls = CL_NOP;
            default:
               d.cls = ext_en ? CL_EXT : CL_ILL;
         endcase
      end
      else
         d.cls = CL_NOP;
      return d;
   endfunction
   function automatic logic [AXI_DATA_W-1:0] wmerge(
      input logic [AXI_DATA_W-1:0] old,
      input logic [AXI_DATA_W-1:0] nw,
      input logic [AXI_STRB_W-1:0] strb
   );
      logic [AXI_DATA_W-1:0] r;
      r = old;
      for (int i = 0; i < AXI_STRB_W; i++)
      begin
         if (strb[i])
            r[i*8 +: 8] = nw[i*8 +: 8];
      end
      return r;
   endfunction
   // ---------------------------------------
   // sequencer
   // ---------------------------------------
   assign redir = st_reg.busy && (st_reg.dec.redirect
      || (st_reg.dec.cond && branch_taken));
   assign fetch_ready = cyc_last && (st_reg.seq == SQ_SECOND
      || ((st_reg.seq == SQ_RUN || st_reg.seq == SQ_FLUSH) && !redir
      && st_reg.ctrl[CTRL_RUN]));
   assign take = fetch_valid && fetch_ready;
   assign first = dec_word(fetch_word, '0, st_reg.ctrl[CTRL_EXT]);
   always_comb
   begin
      st_next = st_reg;
      iss = 1'b0;
      idec = first;
      iw = fetch_word;
      st_next.start = 1'b0;
      if (cyc_last)
      begin
         st_next.busy = 1'b0;
         st_next.cycles = st_reg.cycles + AXI_DATA_W'(1);
         case (st_reg.seq)
            SQ_RUN, SQ_FLUSH:
            begin
               st_next.seq = SQ_RUN;
               if (redir)
                  st_next.seq = SQ_FLUSH;
               else if (take && first.two_word)
               begin
                  st_next.w1 = fetch_word;
                  st_next.seq = SQ_SECOND;
               end
               else if (take)
                  iss = 1'b1;
            end
            SQ_SECOND:
            begin
               if (take)
               begin
                  iss = 1'b1;
                  idec = dec_word(st_reg.w1, fetch_word,
                     st_reg.ctrl[CTRL_EXT]);
                  iw = st_reg.w1;
                  st_next.seq = SQ_RUN;
               end
            end
            default:
               st_next.seq = SQ_RUN;
         endcase
      end
      if (iss)
      begin
         st_next.dec = idec;
         st_next.busy = 1'b1;
         st_next.start = 1'b1;
         st_next.last_w = iw;
         st_next.ill = (idec.cls == CL_ILL);
      end
      // register slave write side
      if (awvalid && awready)
      begin
         st_next.aw_done = 1'b1;
         st_next.awaddr = awaddr;
      end
      if (wvalid && wready)
      begin
         st_next.w_done = 1'b1;
         st_next.wdata = wdata;
         st_next.wstrb = wstrb;
      end
      if (st_reg.aw_done && st_reg.w_done && !st_reg.bvalid)
      begin
         st_next.aw_done = 1'b0;
         st_next.w_done = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp = RESP_OKAY;
         case (st_reg.awaddr)
            REG_CTRL:
               st_next.ctrl = wmerge(st_reg.ctrl, st_reg.wdata,
                  st_reg.wstrb);
            REG_STATUS, REG_CYCLES, REG_WORD, REG_FLAGS:
               st_next.bresp = RESP_OKAY;
            default:
               st_next.bresp = RESP_SLVERR;
         endcase
      end
      else if (st_reg.bvalid && bready)
         st_next.bvalid = 1'b0;
      // register slave read side
      if (arvalid && arready)
      begin
         st_next.rvalid = 1'b1;
         st_next.rresp = RESP_OKAY;
         case (araddr)
            REG_CTRL:
               st_next.rdata = st_reg.ctrl;
            REG_STATUS:
               st_next.rdata = AXI_DATA_W'({st_reg.ill, st_reg.seq,
                  st_reg.dec.cls});
            REG_CYCLES:
               st_next.rdata = st_reg.cycles;
            REG_WORD:
               st_next.rdata = AXI_DATA_W'(st_reg.last_w);
            REG_FLAGS:
               st_next.rdata = AXI_DATA_W'(flags_q);
            default:
            begin
               st_next.rdata = '0;
               st_next.rresp = RESP_SLVERR;
            end
         endcase
      end
      else if (st_reg.rvalid && rready)
         st_next.rvalid = 1'b0;
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_reg <= '0;
         st_reg.ctrl <= CTRL_RST;
      end
      else
         st_reg <= st_next;
   end
   // ---------------------------------------
   // outputs
   // ---------------------------------------
   assign exec_start = st_reg.start;
   assign exec_dec = st_reg.dec;
   assign exec_we = st_reg.busy && st_reg.dec.cls != CL_NOP
      && st_reg.dec.cls != CL_ILL;
   assign data_addr = st_reg.dec.banked
      ? {bank_select_reg, st_reg.dec.fa}
      : {ACCESS_BANK, st_reg.dec.fa};
   assign wr_accum = exec_we && st_reg.dec.cls == CL_BYTE
      && !st_reg.dec.to_file;
   assign wr_file = exec_we && ((st_reg.dec.cls == CL_BYTE
      && st_reg.dec.to_file) || (st_reg.dec.cls == CL_BIT
      && !st_reg.dec.cond) || st_reg.dec.cls == CL_MOVE);
   assign shadow_save = st_reg.start && st_reg.dec.fast
      && st_reg.dec.cls == CL_CALL;
   assign shadow_restore = st_reg.start && st_reg.dec.fast
      && st_reg.dec.cls == CL_RET;
   assign tbl_pre_inc = st_reg.start && (st_reg.dec.cls == CL_TBLRD
      || st_reg.dec.cls == CL_TBLWT)
      && st_reg.dec.tmode == TM_PRE_INC;
   assign tbl_post_inc = st_reg.busy && cyc_last
      && (st_reg.dec.cls == CL_TBLRD || st_reg.dec.cls == CL_TBLWT)
      && st_reg.dec.tmode == TM_POST_INC;
   assign tbl_post_dec = st_reg.busy && cyc_last
      && (st_reg.dec.cls == CL_TBLRD || st_reg.dec.cls == CL_TBLWT)
      && st_reg.dec.tmode == TM_POST_DEC;
   assign status_flags = flags_q;
   assign awready = !st_reg.aw_done && !st_reg.bvalid;
   assign wready = !st_reg.w_done && !st_reg.bvalid;
   assign bvalid = st_reg.bvalid;
   assign bresp = st_reg.bresp;
   assign arready = !st_reg.rvalid;
   assign rvalid = st_reg.rvalid;
   assign rdata = st_reg.rdata;
   assign rresp = st_reg.rresp;
   // ---------------------------------------
   // sub blocks
   // ---------------------------------------
   mcud_phase u_phase (
      .aclk(aclk),
      .aresetn(aresetn),
      .phase(cyc_phase),
      .cyc_last(cyc_last)
   );
   mcud_flags u_flags (
      .aclk(aclk),
      .aresetn(aresetn),
      .upd(alu_upd && exec_we),
      .sub(alu_sub),
      .opa(alu_a),
      .opb(alu_b),
      .flags(flags_q)
   );
   // ---------------------------------------
   // checks
   // ---------------------------------------
   default clocking dc @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence flush_seq;
      st_reg.seq == SQ_FLUSH [*4] ##1 st_reg.seq != SQ_FLUSH;
   endsequence
   sequence single_seq;
      exec_start ##3 cyc_last;
   endsequence
   redirect_flush_a: assert property (cyc_last && redir
      |=> flush_seq)
      else $error("taken branch lacks one flush cycle");
   single_cycle_a: assert property (exec_start |-> single_seq)
      else $error("exec cycle not four periods");
   flush_quiet_a: assert property (st_reg.seq == SQ_FLUSH
      |-> !exec_we && !wr_file && !wr_accum && !exec_start)
      else $error("write during flush cycle");
   second_nop_a: assert property (take && st_reg.seq == SQ_RUN
      && fetch_word[P_TOP_H:P_TOP_L] == TOP_SECOND
      |=> exec_start && exec_dec.cls == CL_NOP && !exec_we)
      else $error("lone second word not a no-op");
   two_word_a: assert property (take && st_reg.seq == SQ_RUN
      && first.two_word |=> !exec_start [*4] ##1 exec_start
      && exec_dec.two_word)
      else $error("two-word instruction timing wrong");
   dest_sel_a: assert property (exec_we && exec_dec.cls == CL_BYTE
      |-> wr_accum != exec_dec.to_file && wr_file == exec_dec.to_file)
      else $error("destination select wrong");
   access_bank_a: assert property (exec_we && !exec_dec.banked
      |-> data_addr[FADDR_W-1:DATA_W] == ACCESS_BANK)
      else $error("access bank not forced");
   bank_reg_a: assert property (exec_we && exec_dec.banked
      |-> data_addr[FADDR_W-1:DATA_W] == bank_select_reg)
      else $error("bank select ignored");
   shadow_fast_a: assert property (shadow_save || shadow_restore
      |-> exec_dec.fast && exec_start)
      else $error("shadow access without fast bit");
   table_mode_a: assert property (exec_dec.tmode == TM_NONE
      |-> !tbl_pre_inc && !tbl_post_inc && !tbl_post_dec)
      else $error("plain table mode moved pointer");
endmodule // mcud_decoder
`default_nettype wire

// >>> mcud_pkg.sv
// constants and types of the instruction word decoder
`default_nettype none
package mcud_pkg;
   // ---------------------------------------
   // widths
   // ---------------------------------------
   localparam int WORD_W = 16;
   localparam int DATA_W = 8;
   localparam int FADDR_W = 12;
   localparam int BANK_W = 4;
   localparam int LIT_W = 20;
   localparam int PH_W = 2;
   localparam int OSC_PER_CYC = 4;
   localparam int AXI_ADDR_W = 8;
   localparam int AXI_DATA_W = 32;
   localparam int AXI_STRB_W = 4;
   // ---------------------------------------
   // field positions
   // ---------------------------------------
   localparam int P_TOP_H = 15;
   localparam int P_TOP_L = 12;
   localparam int P_SUB_H = 11;
   localparam int P_SUB_L = 9;
   localparam int P_D = 9;
   localparam int P_A = 8;
   localparam int P_S = 8;
   localparam int P_B_H = 11;
   localparam int P_B_L = 9;
   localparam int P_BRC = 11;
   localparam int P_REL_H = 10;
   localparam int P_PS_H = 5;
   localparam int P_PS_L = 4;
   localparam int P_KN_H = 3;
   localparam int P_F_H = 7;
   localparam int P_FS_H = 11;
   localparam int P_TM_H = 1;
   // ---------------------------------------
   // opcode codes
   // ---------------------------------------
   localparam logic [3:0] TOP_BYTE_MAX = 4'h5;
   localparam logic [3:0] TOP_BYTE_SKIP = 4'h5;
   localparam logic [3:0] TOP_BIT_MAX = 4'h9;
   localparam logic [3:0] TOP_BIT_SKIP = 4'h9;
   localparam logic [3:0] TOP_LIT = 4'hA;
   localparam logic [3:0] TOP_PTR = 4'hB;
   localparam logic [3:0] TOP_MOVE = 4'hC;
   localparam logic [3:0] TOP_BRA = 4'hD;
   localparam logic [3:0] TOP_CTL = 4'hE;
   localparam logic [3:0] TOP_SECOND = 4'hF;
   localparam logic [2:0] SUB_GOTO = 3'h0;
   localparam logic [2:0] SUB_CALL = 3'h1;
   localparam logic [2:0] SUB_RET = 3'h2;
   localparam logic [2:0] SUB_TBLRD = 3'h3;
   localparam logic [2:0] SUB_TBLWT = 3'h4;
   localparam logic [2:0] SUB_NOP = 3'h5;
   localparam logic [BANK_W-1:0] ACCESS_BANK = 4'h0;
   // ---------------------------------------
   // register map
   // ---------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_CYCLES = 8'h08;
   localparam logic [7:0] REG_WORD = 8'h0C;
   localparam logic [7:0] REG_FLAGS = 8'h10;
   localparam int CTRL_RUN = 0;
   localparam int CTRL_EXT = 1;
   localparam logic [31:0] CTRL_RST = 32'h0000_0003;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ---------------------------------------
   // types
   // ---------------------------------------
   typedef enum logic [3:0] {
      CL_NOP = 4'h0, CL_BYTE = 4'h1, CL_BIT = 4'h2, CL_LIT = 4'h3,
      CL_PTR = 4'h4, CL_MOVE = 4'h5, CL_BRA = 4'h6, CL_GOTO = 4'h7,
      CL_CALL = 4'h8, CL_RET = 4'h9, CL_TBLRD = 4'hA, CL_TBLWT = 4'hB,
      CL_EXT = 4'hC, CL_ILL = 4'hD
   } mcud_cls_e;
   typedef enum logic [1:0] {
      TM_NONE = 2'h0, TM_POST_INC = 2'h1, TM_POST_DEC = 2'h2,
      TM_PRE_INC = 2'h3
   } mcud_tmode_e;
   typedef enum logic [1:0] {
      SQ_RUN = 2'h0, SQ_SECOND = 2'h1, SQ_FLUSH = 2'h2
   } mcud_seq_e;
   typedef struct packed {
      mcud_cls_e cls;
      logic to_file;
      logic banked;
      logic [2:0] bitn;
      logic [7:0] fa;
      logic [FADDR_W-1:0] fs;
      logic [FADDR_W-1:0] fd;
      logic [LIT_W-1:0] lit;
      logic [1:0] psel;
      mcud_tmode_e tmode;
      logic fast;
      logic redirect;
      logic cond;
      logic two_word;
   } mcud_dec_s;
   typedef struct packed {
      logic n;
      logic ov;
      logic z;
      logic dc;
      logic c;
   } mcud_flags_s;
endpackage
`default_nettype wire

// >>> mcud_phase.sv
// instruction cycle phase counter
`timescale 1ns/1ps
`default_nettype none
module mcud_phase
#(
   parameter int PERIODS = mcud_pkg::OSC_PER_CYC
)
(
   input wire logic aclk,
   input wire logic aresetn,
   output logic [mcud_pkg::PH_W-1:0] phase,
   output logic cyc_last
);
   import mcud_pkg::*;
   typedef struct packed {
      logic [PH_W-1:0] cnt;
   } mcud_ph_s;
   mcud_ph_s st_reg;
   mcud_ph_s st_next;
   // ---------------------------------------
   // four periods per cycle
   // ---------------------------------------
   always_comb
   begin
      st_next = st_reg;
      if (st_reg.cnt == PH_W'(PERIODS - 1))
         st_next.cnt = '0;
      else
         st_next.cnt = st_reg.cnt + PH_W'(1);
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end
   assign phase = st_reg.cnt;
   assign cyc_last = (st_reg.cnt == PH_W'(PERIODS - 1));
   phase_wrap_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      cyc_last |=> !cyc_last [*3] ##1 cyc_last)
      else $error("cycle is not four periods");
endmodule // mcud_phase
`default_nettype wire

// >>> mcud_flags.sv
// arithmetic status flag register
`timescale 1ns/1ps
`default_nettype none
module mcud_flags
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic upd,
   input wire logic sub,
   input wire logic [mcud_pkg::DATA_W-1:0] opa,
   input wire logic [mcud_pkg::DATA_W-1:0] opb,
   output mcud_pkg::mcud_flags_s flags
);
   import mcud_pkg::*;
   typedef struct packed {
      mcud_flags_s f;
   } mcud_fl_s;
   mcud_fl_s st_reg;
   mcud_fl_s st_next;
   logic [DATA_W-1:0] b_eff;
   logic [DATA_W:0] sum;
   logic [DATA_W/2:0] low;
   // ---------------------------------------
   // add or subtract, five flags
   // ---------------------------------------
   always_comb
   begin
      b_eff = sub ? ~opb : opb;
      sum = {1'b0, opa} + {1'b0, b_eff} + (DATA_W+1)'(sub);
      low = {1'b0, opa[DATA_W/2-1:0]} + {1'b0, b_eff[DATA_W/2-1:0]}
         + (DATA_W/2+1)'(sub);
      st_next = st_reg;
      if (upd)
      begin
         st_next.f.c = sum[DATA_W];
         st_next.f.dc = low[DATA_W/2];
         st_next.f.z = (sum[DATA_W-1:0] == '0);
         st_next.f.ov = (opa[DATA_W-1] == b_eff[DATA_W-1])
            && (sum[DATA_W-1] != opa[DATA_W-1]);
         st_next.f.n = sum[DATA_W-1];
      end
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end
   assign flags = st_reg.f;
   zero_sub_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      upd && sub && opa == opb |=> flags.z && flags.c && !flags.n)
      else $error("equal subtract flags wrong");
endmodule // mcud_flags
`default_nettype wire

// >>> mcud_fetch_model.sv
// program fetch model feeding instruction words in order
`timescale 1ns/1ps
`default_nettype none
module mcud_fetch_model
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic fetch_ready,
   output logic fetch_valid = 1'b0,
   output logic [15:0] fetch_word = 16'h0000
);
   import mcud_pkg::*;
   logic [WORD_W-1:0] q[$];
   logic tk;
   task push(input logic [WORD_W-1:0] w);
      q.push_back(w);
   endtask
   always @(negedge aclk) tk = fetch_valid && fetch_ready;
   // words leave in program order, second word right after first
   always @(posedge aclk)
   begin
      if (!aresetn)
         fetch_valid <= 1'b0;
      else
      begin
         if (tk)
            void'(q.pop_front());
         fetch_valid <= q.size() > 0;
         fetch_word <= (q.size() > 0) ? q[0] : ~fetch_word;
      end
   end
endmodule // mcud_fetch_model
`default_nettype wire

// >>> tb_mcud_decoder.sv
// testbench of the instruction word decoder
`timescale 1ns/1ps
`default_nettype none
module tb_mcud_decoder;
   import mcud_pkg::*;
   logic aclk = 0, aresetn = 0, fetch_valid, fetch_ready, exec_start;
   logic exec_we, wr_accum, wr_file, shadow_save, shadow_restore;
   logic tbl_pre_inc, awvalid = 0, awready, wvalid = 0, wready, bvalid;
   logic bready = 0, arvalid = 0, arready, rvalid, rready = 0;
   logic [WORD_W-1:0] fetch_word;
   logic [FADDR_W-1:0] data_addr;
   logic [BANK_W-1:0] bank_select_reg = 4'h7;
   logic [AXI_STRB_W-1:0] wstrb = 4'hF;
   logic [AXI_ADDR_W-1:0] awaddr = 0, araddr = 0;
   logic [AXI_DATA_W-1:0] wdata = 0, rdata, rd;
   logic [1:0] bresp, rresp, rs;
   logic tbl_post_inc, tbl_post_dec, branch_taken = 0, alu_upd = 0;
   logic alu_sub = 0;
   logic [DATA_W-1:0] alu_a = 0, alu_b = 0;
   logic [PH_W-1:0] cyc_phase;
   mcud_flags_s status_flags;
   mcud_dec_s exec_dec;
   int failures = 0, cmp_count = 0, cyc = 0;
   realtime t0;
   mcud_decoder i_mcud_decoder (.aclk, .aresetn, .fetch_valid, .fetch_word,
      .fetch_ready, .branch_taken, .bank_select_reg, .alu_upd, .alu_sub,
      .alu_a, .alu_b, .exec_start, .exec_dec,
      .exec_we, .data_addr, .wr_accum, .wr_file, .shadow_save,
      .shadow_restore, .tbl_pre_inc, .tbl_post_inc, .tbl_post_dec,
      .cyc_phase, .status_flags, .awaddr, .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready);
   mcud_fetch_model i_mcud_fetch_model (.aclk, .aresetn, .fetch_ready,
      .fetch_valid, .fetch_word);
   // ---------------------------------------
   // tasks
   // ---------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         failures++;
         $display("Error at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task give_verdict;
      $display("failures %0d compares %0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
      logic ah, wh, rh, done;
      @(posedge aclk);
      awaddr <= a;
      araddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= {3{wr}};
      {arvalid, rready} <= {2{!wr}};
      done = 0;
      while (!done)
      begin
         @(negedge aclk);
         ah = awvalid && awready;
         wh = wvalid && wready;
         rh = arvalid && arready;
         done = wr ? bvalid : rvalid;
         rd = rdata;
         rs = wr ? bresp : rresp;
         @(posedge aclk);
         if (ah) awvalid <= 0;
         if (wh) wvalid <= 0;
         if (rh) arvalid <= 0;
         if (done) {bready, rready} <= 2'b00;
      end
   endtask
   task alu(input logic s, input logic [7:0] a, input logic [7:0] b,
      input logic [4:0] e);
      @(posedge aclk);
      {alu_upd, alu_sub, alu_a, alu_b} <= {1'b1, s, a, b};
      @(posedge aclk);
      alu_upd <= 1'b0;
      @(negedge aclk);
      chk(status_flags, e);
   endtask
   task go(input logic [15:0] w1, input logic [15:0] w2, input logic two);
      int n;
      i_mcud_fetch_model.push(w1);
      if (two) i_mcud_fetch_model.push(w2);
      n = 0;
      @(negedge aclk);
      while (exec_start !== 1'b1 && n < 60)
      begin
         @(negedge aclk);
         n++;
      end
      if (n == 60) chk(0, 1);
   endtask
   // ---------------------------------------
   // run
   // ---------------------------------------
   initial forever #5 aclk = ~aclk;
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         failures++;
         give_verdict;
      end
   end
   initial
   begin
      repeat (10) @(posedge aclk);
      aresetn <= 1;
      axi(0, REG_CTRL, 0); chk(rd, CTRL_RST);
      axi(0, 8'hFC, 0); chk(rs, RESP_SLVERR);
      axi(1, REG_CTRL, 32'h1);
      go(16'hEC00, 0, 0); chk(exec_dec.cls, CL_ILL);
      axi(1, REG_CTRL, CTRL_RST);
      go(16'hEC00, 0, 0); chk(exec_dec.cls, CL_EXT);
      for (int i = 0; i < 4; i++)
      begin
         go({4'h2, 2'b00, i[1], i[0], 8'h5A}, 0, 0);
         chk(exec_dec.cls, CL_BYTE);
         chk(exec_we, 1);
         chk({wr_file, wr_accum}, {i[1], !i[1]});
         chk(data_addr, i[0] ? 12'h75A : 12'h05A);
      end
      for (int b = 0; b < 8; b++)
      begin
         go({4'h7, b[2:0], 1'b0, 8'h33}, 0, 0);
         chk(exec_dec.bitn, b);
      end
      go(16'hA07F, 0, 0); chk(exec_dec.lit[7:0], 8'h7F);
      go(16'hB025, 16'hF0C3, 1); chk(exec_dec.psel, 2);
      chk(exec_dec.lit[11:0], 12'h5C3);
      go(16'hCABC, 16'hF456, 1); chk(exec_dec.two_word, 1);
      chk({exec_dec.fs, exec_dec.fd}, 24'hABC456);
      go(16'hE034, 16'hF123, 1); chk(exec_dec.lit, 20'h12334);
      go(16'hE300, 16'hF000, 1); chk(shadow_save, 1);
      go(16'hE200, 16'hF000, 1); chk(shadow_save, 0);
      go(16'hE500, 0, 0); chk(shadow_restore, 1);
      go(16'hFABC, 0, 0); chk(exec_dec.cls, CL_NOP);
      chk(exec_we, 0);
      for (int m = 0; m < 4; m++)
      begin
         go({4'hE, 3'h3, 7'h00, m[1:0]}, 0, 0);
         chk(exec_dec.tmode, m);
         chk(tbl_pre_inc, m == 3);
         repeat (3) @(negedge aclk);
         chk({tbl_post_inc, tbl_post_dec}, {m == 1, m == 2});
      end
      go(16'h235A, 16'h235A, 1);
      t0 = $realtime;
      go(16'h235A, 0, 0); chk(($realtime - t0) / 10, 4);
      chk(cyc_phase, 0);
      go(16'h235A, 0, 0); alu(1, 8'h3C, 8'h3C, 5'h07);
      go(16'h235A, 0, 0); alu(0, 8'h7F, 8'h01, 5'h1A);
      axi(0, REG_FLAGS, 0); chk(rd, 32'h1A);
      go(16'hD005, 0, 0); t0 = $realtime;
      go(16'h235A, 0, 0); chk(($realtime - t0) / 10, 8);
      @(posedge aclk) branch_taken <= 1'b1;
      go(16'hD803, 0, 0); t0 = $realtime;
      go(16'h235A, 0, 0); chk(($realtime - t0) / 10, 8);
      give_verdict;
   end
endmodule // tb_mcud_decoder
`default_nettype wire
